// ==== verilog/dbg_port.sv ====
// Eight-bit general purpose port shared with the external data bus.
//
// Contract
// - Direction register is write-only; reading it gives a fixed value.
// - Direction, output and pull-up clear on power-on or hardware standby.
// - Modes 1, 2, 4, 5, 6 ignore direction; pins carry data bus.
// - Modes 3 and 7: direction bit 1 outputs, 0 inputs, per pin.
// - Output data register is readable, writable and drives output pins.
// - Pin state register is read-only; writes to it are ignored.
// - Pin state reads output data where direction 1, pin where 0.
// - Pin state follows pins after reset; frozen in manual reset, software standby.
// - Pull-up control register is readable, writable, one bit per pin.
// - Pull-up on only in modes 3, 7 with direction 0, pull-up 1.
// - Pull-ups off after reset, hardware standby; kept through manual reset, software standby.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "dbg_map.svh"

module dbg_port (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire dbg_pkg::dbg_addr_t s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire dbg_pkg::dbg_addr_t s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire dbg_pkg::dbg_mode_t op_mode,
  input  wire logic               hw_standby,
  input  wire logic               manual_reset,
  input  wire logic               sw_standby,
  input  wire logic               ext_bus_oe,
  input  wire dbg_pkg::dbg_byte_t ext_bus_dout,
  output dbg_pkg::dbg_byte_t      ext_bus_din,
  input  wire dbg_pkg::dbg_byte_t pin_in,
  output dbg_pkg::dbg_byte_t      pin_out,
  output dbg_pkg::dbg_byte_t      pin_oe,
  output dbg_pkg::dbg_byte_t      pullup_en
);
  import dbg_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations.

  dbg_byte_t pin_sync;
  dbg_byte_t pin_direction_q;
  dbg_byte_t output_data_q;
  dbg_byte_t pullup_control_q;
  dbg_byte_t pin_state_q;
  dbg_byte_t pin_state_d;
  dbg_byte_t pin_out_q;
  dbg_byte_t pin_oe_q;
  dbg_byte_t pullup_en_q;
  dbg_byte_t ext_bus_din_q;

  logic      aw_full_q;
  dbg_addr_t awaddr_q;
  logic      w_full_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic      awready_q;
  logic      wready_q;
  logic      bvalid_q;
  logic [1:0] bresp_q;
  logic      arready_q;
  logic      rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic      gpio_mode;
  logic      freeze;
  logic      wr_en;
  logic      rd_take;
  dbg_reg_e  wsel;
  dbg_reg_e  rsel;

  //////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Maps a byte address onto a register of the port.
  function automatic dbg_reg_e reg_decode(input dbg_addr_t addr);
    case (addr)
      `DBG_OFF_DIR: reg_decode = DBG_REG_DIR;
      `DBG_OFF_ODR: reg_decode = DBG_REG_ODR;
      `DBG_OFF_PIN: reg_decode = DBG_REG_PIN;
      `DBG_OFF_PUP: reg_decode = DBG_REG_PUP;
      default:      reg_decode = DBG_REG_NONE;
    endcase
  endfunction : reg_decode

  // True in the single chip modes where the pins are general I/O.
  function automatic logic is_gpio_mode(input dbg_mode_t mode);
    is_gpio_mode = (mode == `DBG_MODE_GPIO_A) ||
                   (mode == `DBG_MODE_GPIO_B);
  endfunction : is_gpio_mode

  //////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser.

  dbg_sync i_dbg_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pin_in),
    .q       (pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////
  // Common decode.

  assign gpio_mode = is_gpio_mode(op_mode);
  assign freeze    = manual_reset || sw_standby;
  assign wr_en     = aw_full_q && w_full_q && !bvalid_q;
  assign rd_take   = s_axi_arvalid && arready_q;
  assign wsel      = reg_decode(awaddr_q);
  assign rsel      = reg_decode(s_axi_araddr);

  //////////////////////////////////////////////////////////////////////////
  // Write address and data capture, in either order.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_en) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `DBG_RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wsel == DBG_REG_NONE) ? `DBG_RESP_SLVERR
                                         : `DBG_RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Port registers.

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      pin_direction_q <= `DBG_DIR_RESET;
    end else if (wr_en && wsel == DBG_REG_DIR && wstrb_q[0]) begin
      pin_direction_q <= wdata_q[`DBG_DATA_MSB:`DBG_DATA_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      output_data_q <= `DBG_ODR_RESET;
    end else if (wr_en && wsel == DBG_REG_ODR && wstrb_q[0]) begin
      output_data_q <= wdata_q[`DBG_DATA_MSB:`DBG_DATA_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      pullup_control_q <= `DBG_PUP_RESET;
    end else if (wr_en && wsel == DBG_REG_PUP && wstrb_q[0]) begin
      pullup_control_q <= wdata_q[`DBG_DATA_MSB:`DBG_DATA_LSB];
    end
  end

  // Output bits report their latch, input bits the live pin.
  assign pin_state_d = (pin_direction_q & output_data_q) |
                       (~pin_direction_q & pin_sync);

  // Pin state freezes during manual reset and software standby.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_state_q <= `DBG_PIN_RESET;
    end else if (hw_standby || !freeze) begin
      pin_state_q <= pin_state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read channel; the pin state register has no write path at all.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
    end else if (rd_take) begin
      arready_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `DBG_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `DBG_RESP_OKAY;
      case (rsel)
        DBG_REG_DIR: rdata_q <= {24'h000000, `DBG_DIR_READ};
        DBG_REG_ODR: rdata_q <= {24'h000000, output_data_q};
        DBG_REG_PIN: rdata_q <= {24'h000000, pin_state_q};
        DBG_REG_PUP: rdata_q <= {24'h000000, pullup_control_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `DBG_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drive, pull-ups and data bus input.

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      pin_oe_q  <= 8'h00;
      pin_out_q <= 8'h00;
    end else if (gpio_mode) begin
      pin_oe_q  <= pin_direction_q;
      pin_out_q <= output_data_q;
    end else begin
      pin_oe_q  <= {8{ext_bus_oe}};
      pin_out_q <= ext_bus_dout;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby || !gpio_mode) begin
      pullup_en_q <= 8'h00;
    end else begin
      pullup_en_q <= ~pin_direction_q & pullup_control_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_bus_din_q <= 8'h00;
    end else begin
      ext_bus_din_q <= pin_sync;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign pin_out       = pin_out_q;
  assign pin_oe        = pin_oe_q;
  assign pullup_en     = pullup_en_q;
  assign ext_bus_din   = ext_bus_din_q;

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_dir;
    rd_take && rsel == DBG_REG_DIR;
  endsequence

  sequence s_wr_pin;
    wr_en && wsel == DBG_REG_PIN;
  endsequence

  property p_dir_read;
    s_rd_dir |=> rvalid_q && rdata_q == 32'h0000_0000;
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("Direction read returned the stored setting.");

  property p_hw_clear;
    hw_standby |=> pin_direction_q == 8'h00 && output_data_q == 8'h00 &&
                   pullup_control_q == 8'h00;
  endproperty
  a_hw_clear: assert property (p_hw_clear)
    else $error("Registers not cleared in hardware standby.");

  property p_manual_keep;
    manual_reset && !hw_standby && !wr_en |=>
      pin_direction_q == $past(pin_direction_q) &&
      pullup_control_q == $past(pullup_control_q);
  endproperty
  a_manual_keep: assert property (p_manual_keep)
    else $error("Registers changed during manual reset.");

  property p_bus_mode;
    !gpio_mode && !hw_standby |=>
      pin_oe_q == {8{$past(ext_bus_oe)}} && pin_out_q == $past(ext_bus_dout);
  endproperty
  a_bus_mode: assert property (p_bus_mode)
    else $error("Data bus mode pins not driven by bus controller.");

  property p_gpio_drive;
    gpio_mode && !hw_standby |=>
      pin_oe_q == $past(pin_direction_q) && pin_out_q == $past(output_data_q);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive)
    else $error("General I/O pins not following direction and data.");

  property p_odr_write;
    wr_en && wsel == DBG_REG_ODR && wstrb_q[0] |=>
      bvalid_q && output_data_q == $past(wdata_q[7:0]);
  endproperty
  a_odr_write: assert property (p_odr_write)
    else $error("Output data write not stored.");

  property p_pin_ignore;
    s_wr_pin |=> output_data_q == $past(output_data_q);
  endproperty
  a_pin_ignore: assert property (p_pin_ignore)
    else $error("Write to pin state changed output data.");

  property p_pin_mix;
    !freeze |=> pin_state_q == (($past(pin_direction_q) &
      $past(output_data_q)) | (~$past(pin_direction_q) & $past(pin_sync)));
  endproperty
  a_pin_mix: assert property (p_pin_mix)
    else $error("Pin state does not mix data and pin levels.");

  property p_pin_hold;
    freeze && !hw_standby |=> $stable(pin_state_q);
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("Pin state changed while frozen.");

  property p_pu_on;
    gpio_mode && !hw_standby |=>
      pullup_en_q == (~$past(pin_direction_q) & $past(pullup_control_q));
  endproperty
  a_pu_on: assert property (p_pu_on)
    else $error("Pull-up enable mismatch in general I/O mode.");

  property p_pu_off;
    !gpio_mode || hw_standby |=> pullup_en_q == 8'h00;
  endproperty
  a_pu_off: assert property (p_pu_off)
    else $error("Pull-up enabled in bus mode or standby.");

endmodule : dbg_port

// ==== verilog/dbg_map.svh ====
// Register offsets, field positions, reset values and mode codes.
`ifndef DBG_MAP_SVH
`define DBG_MAP_SVH

`define DBG_OFF_DIR      12'h000
`define DBG_OFF_ODR      12'h004
`define DBG_OFF_PIN      12'h008
`define DBG_OFF_PUP      12'h00C

`define DBG_DATA_MSB     7
`define DBG_DATA_LSB     0

`define DBG_DIR_RESET    8'h00
`define DBG_ODR_RESET    8'h00
`define DBG_PUP_RESET    8'h00
`define DBG_PIN_RESET    8'h00
`define DBG_DIR_READ     8'h00

`define DBG_MODE_GPIO_A  3'h3
`define DBG_MODE_GPIO_B  3'h7

`define DBG_RESP_OKAY    2'h0
`define DBG_RESP_SLVERR  2'h2

`endif

// ==== verilog/dbg_pkg.sv ====
// Types shared by the data bus shared port.
package dbg_pkg;

  typedef logic [2:0]  dbg_mode_t;
  typedef logic [7:0]  dbg_byte_t;
  typedef logic [11:0] dbg_addr_t;

  typedef enum logic [2:0] {
    DBG_REG_DIR,
    DBG_REG_ODR,
    DBG_REG_PIN,
    DBG_REG_PUP,
    DBG_REG_NONE
  } dbg_reg_e;

endpackage : dbg_pkg

// ==== verilog/dbg_sync.sv ====
// Two flip-flop synchroniser for the eight port pin levels.
`timescale 1ns/10ps

module dbg_sync (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire dbg_pkg::dbg_byte_t d,
  output dbg_pkg::dbg_byte_t   q
);
  import dbg_pkg::*;

  dbg_byte_t meta_q;
  dbg_byte_t sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule : dbg_sync

// ==== sim/dbg_pins_model.sv ====
// Model of the port pins with an outside driver and the pull-ups.
`timescale 1ns/10ps

module dbg_pins_model
  import dbg_pkg::*;
(
  input  wire logic               aclk,
  input  wire dbg_pkg::dbg_byte_t pin_out,
  input  wire dbg_pkg::dbg_byte_t pin_oe,
  input  wire dbg_pkg::dbg_byte_t pullup_en,
  input  wire dbg_pkg::dbg_byte_t drv_en,
  input  wire dbg_pkg::dbg_byte_t drv_val,
  output dbg_pkg::dbg_byte_t      pin_lvl
);
  dbg_byte_t float_q = 8'h55;

  // A pin that nobody drives and nothing pulls up flips every cycle.
  always_ff @(posedge aclk) begin
    float_q <= ~float_q;
  end

  // Port drive wins, then the outside driver, then the pull-up.
  always_comb begin
    pin_lvl = (pin_oe & pin_out)
            | (~pin_oe & drv_en & drv_val)
            | (~pin_oe & ~drv_en & pullup_en)
            | (~pin_oe & ~drv_en & ~pullup_en & float_q);
  end
endmodule : dbg_pins_model

// ==== sim/dbg_port_tb.sv ====
// Self-checking testbench of the data bus shared port.
`timescale 1ns/10ps
`include "dbg_map.svh"

module dbg_port_tb;
  import dbg_pkg::*;
  logic        aclk;
  logic        aresetn;
  dbg_addr_t   s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  dbg_addr_t   s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  dbg_mode_t   op_mode;
  logic        hw_standby;
  logic        manual_reset;
  logic        sw_standby;
  logic        ext_bus_oe;
  dbg_byte_t   ext_bus_dout;
  dbg_byte_t   ext_bus_din;
  dbg_byte_t   pin_in;
  dbg_byte_t   pin_out;
  dbg_byte_t   pin_oe;
  dbg_byte_t   pullup_en;
  dbg_byte_t   drv_en;
  dbg_byte_t   drv_val;
  int          mismatches;
  int          checked;
  int          cycles;
  dbg_mode_t   bus_modes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

  dbg_port i_dbg_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_mode, .hw_standby,
    .manual_reset, .sw_standby, .ext_bus_oe, .ext_bus_dout, .ext_bus_din,
    .pin_in, .pin_out, .pin_oe, .pullup_en);

  dbg_pins_model i_dbg_pins_model (.aclk, .pin_out, .pin_oe, .pullup_en,
    .drv_en, .drv_val, .pin_lvl(pin_in));

  always #2.5 aclk = ~aclk;

  //////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt

  // Write one word; address and data are offered together.
  task automatic wr(input dbg_addr_t a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input dbg_addr_t a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd

  //////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    aclk = 0; aresetn = 0; s_axi_awaddr = 0; s_axi_awvalid = 0;
    s_axi_wdata = 0; s_axi_wstrb = 4'hF; s_axi_wvalid = 0;
    s_axi_bready = 1; s_axi_araddr = 0; s_axi_arvalid = 0;
    s_axi_rready = 1; op_mode = 3'h3; hw_standby = 0; manual_reset = 0;
    sw_standby = 0; ext_bus_oe = 0; ext_bus_dout = 0; drv_en = 0;
    drv_val = 0; mismatches = 0; checked = 0; cycles = 0;
    wt(20);
    aresetn <= 1'b1;
    wt(2);
    rd(`DBG_OFF_ODR, 32'h00, `DBG_RESP_OKAY);
    rd(`DBG_OFF_PUP, 32'h00, `DBG_RESP_OKAY);
    wr(`DBG_OFF_DIR, 32'hA5, `DBG_RESP_OKAY);
    rd(`DBG_OFF_DIR, 32'h00, `DBG_RESP_OKAY);
    wr(`DBG_OFF_ODR, 32'h3C, `DBG_RESP_OKAY);
    rd(`DBG_OFF_ODR, 32'h3C, `DBG_RESP_OKAY);
    // A write with the low byte lane disabled leaves the register alone.
    s_axi_wstrb <= 4'h0;
    wr(`DBG_OFF_ODR, 32'hFF, `DBG_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`DBG_OFF_ODR, 32'h3C, `DBG_RESP_OKAY);
    wr(`DBG_OFF_PUP, 32'h5A, `DBG_RESP_OKAY);
    rd(`DBG_OFF_PUP, 32'h5A, `DBG_RESP_OKAY);
    drv_en <= 8'h50;
    wt(6);
    chk(32'(pin_oe), 32'hA5);
    chk(32'(pin_out & pin_oe), 32'h24);
    chk(32'(pullup_en), 32'h5A);
    rd(`DBG_OFF_PIN, 32'h2E, `DBG_RESP_OKAY);
    wr(`DBG_OFF_PIN, 32'hFF, `DBG_RESP_OKAY);
    rd(`DBG_OFF_PIN, 32'h2E, `DBG_RESP_OKAY);
    wr(12'h010, 32'h11, `DBG_RESP_SLVERR);
    rd(12'h010, 32'h00, `DBG_RESP_SLVERR);
    // Manual reset, then software standby: state and pin view are held.
    for (int i = 0; i < 2; i++) begin
      if (i == 0) begin
        manual_reset <= 1'b1;
      end else begin
        sw_standby <= 1'b1;
      end
      drv_val <= 8'h50;
      wt(6);
      rd(`DBG_OFF_PIN, 32'h2E, `DBG_RESP_OKAY);
      rd(`DBG_OFF_ODR, 32'h3C, `DBG_RESP_OKAY);
      chk(32'(pullup_en), 32'h5A);
      manual_reset <= 1'b0;
      sw_standby <= 1'b0;
      drv_val <= 8'h00;
      wt(6);
    end
    // Data bus modes hand the pins to the bus controller.
    ext_bus_oe <= 1'b1;
    ext_bus_dout <= 8'h96;
    for (int i = 0; i < 5; i++) begin
      op_mode <= bus_modes[i];
      wt(6);
      chk(32'(pin_oe), 32'hFF);
      chk(32'(pin_out), 32'h96);
      chk(32'(pullup_en), 32'h00);
      chk(32'(ext_bus_din), 32'h96);
    end
    ext_bus_oe <= 1'b0;
    wt(2);
    chk(32'(pin_oe), 32'h00);
    op_mode <= 3'h7;
    wt(2);
    chk(32'(pin_oe), 32'hA5);
    chk(32'(pullup_en), 32'h5A);
    // Hardware standby clears the registers and releases the pins.
    hw_standby <= 1'b1;
    wt(2);
    chk(32'(pin_oe), 32'h00);
    chk(32'(pullup_en), 32'h00);
    hw_standby <= 1'b0;
    wt(1);
    rd(`DBG_OFF_ODR, 32'h00, `DBG_RESP_OKAY);
    rd(`DBG_OFF_PUP, 32'h00, `DBG_RESP_OKAY);
    drv_en <= 8'hFF;
    drv_val <= 8'h81;
    wt(6);
    rd(`DBG_OFF_PIN, 32'h81, `DBG_RESP_OKAY);
    results();
  end
endmodule : dbg_port_tb
